// ==== common/cct_consts.svh ====
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH
// register byte offsets, one aligned word each
`define WK_CTRL_OFS 8'h00
`define CAM_DAYS_OFS 8'h04
`define CAM_TIME_OFS 8'h10
`define DATE_CTRL_OFS 8'h20
`define DATE_ON_OFS 8'h24
`define DATE_OFF_OFS 8'h28
`define STATUS_OFS 8'h2c
`define WORD_BYTES 8'h04
`define NUM_CAMS 3
// cam time word: on time low half, off time high half
`define ON_MIN_LSB 0
`define ON_HR_LSB 8
`define ON_UNSET_BIT 15
`define OFF_MIN_LSB 16
`define OFF_HR_LSB 24
`define OFF_UNSET_BIT 31
`define CAM_TIME_MASK 32'h9f3f_9f3f
`define CAM_TIME_RST 32'h8000_8000
// date word: year as offset from 2000, month, day
`define YR_LSB 0
`define MON_LSB 8
`define DAY_LSB 16
// mode and status bits
`define WK_PULSE_BIT 0
`define MODE_MONTHLY 0
`define MODE_YEARLY 1
`define MODE_PULSE 2
`define STAT_WK_BIT 0
`define STAT_DT_BIT 1
// calendar limits
`define LAST_YEAR 7'd99
`define LAST_HOUR 5'd23
`define LAST_MIN 6'd59
`define NO_WDAY 3'd7
`define FIRST_MONTH 4'd1
`define LAST_MONTH 4'd12
`define MIDNIGHT_HR 5'd0
`define MIDNIGHT_MIN 6'd0
// last-seen stamps start impossible so the first scan evaluates
`define WK_SEEN_RST 14'h3fff
`define DAY_SEEN_RST 16'hffff
`endif

// ==== common/cct_pkg.sv ====
`include "cct_consts.svh"

package cct_pkg;
  typedef struct packed {
    logic [6:0] yr;
    logic [3:0] mon;
    logic [4:0] day;
  } date_t;

  typedef struct packed {
    logic [2:0] wday;
    logic [4:0] hr;
    logic [5:0] mn;
  } wtime_t;

  typedef struct packed {
    date_t d;
    wtime_t w;
  } rtc_t;

  typedef struct packed {
    rtc_t s1;
    rtc_t s2;
    rtc_t s3;
    rtc_t now;
    logic wk_pulse;
    logic [`NUM_CAMS-1:0][6:0] days;
    logic [`NUM_CAMS-1:0][31:0] times;
    logic [2:0] mode;
    date_t don;
    date_t doff;
    wtime_t wk_seen;
    date_t dt_seen;
    logic wk_q;
    logic dt_q;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cct_state_t;
endpackage : cct_pkg

// ==== verilog/weekly_cam_match.sv ====
`timescale 1ns/1ps
`include "cct_consts.svh"

module weekly_cam_match (
  input wire logic [6:0] days_i,
  input wire logic [31:0] time_i,
  input wire cct_pkg::wtime_t now_i,
  output logic on_hit_o,
  output logic off_hit_o
);
  import cct_pkg::*;

  logic day_sel;
  logic on_ok;
  logic off_ok;

  // R01: weekday mask gate
  assign day_sel = (now_i.wday != `NO_WDAY) && days_i[now_i.wday];

  // R02: out-of-range times act as unset
  // R04: unset times never switch
  assign on_ok = !time_i[`ON_UNSET_BIT]
    && (time_i[`ON_HR_LSB +: 5] <= `LAST_HOUR)
    && (time_i[`ON_MIN_LSB +: 6] <= `LAST_MIN);
  assign off_ok = !time_i[`OFF_UNSET_BIT]
    && (time_i[`OFF_HR_LSB +: 5] <= `LAST_HOUR)
    && (time_i[`OFF_MIN_LSB +: 6] <= `LAST_MIN);

  // hits last the whole matching minute
  assign on_hit_o = day_sel && on_ok
    && (now_i.hr == time_i[`ON_HR_LSB +: 5])
    && (now_i.mn == time_i[`ON_MIN_LSB +: 6]);
  assign off_hit_o = day_sel && off_ok
    && (now_i.hr == time_i[`OFF_HR_LSB +: 5])
    && (now_i.mn == time_i[`OFF_MIN_LSB +: 6]);
endmodule : weekly_cam_match

// ==== verilog/calendar_cam_timer.sv ====
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Contract
// R01: each cam has a seven-day mask; cleared day never switches
// R02: cam times are hour and minute, 00:00 to 23:59
// R03: weekly pulse mode asserts output for exactly one scan
// R04: an unset cam time causes no switching
// R05: three cams jointly drive the weekly output
// R06: on overlap, earliest on and earliest off decide
// R07: dates limited to years 2000 through 2099
// R08: date timer switches only at midnight; only pulse mode waits for 00:00, level modes switch at any scan
// R09: date fields ordered year, month, day
// R10: monthly mode: on at on-day, off at off-day, within years
// R11: yearly mode: on at on month-day, off at off month-day
// R12: monthly and yearly both set: monthly recurrence applies
// R13: date pulse mode: one-scan pulse per on-date occurrence
// R14: no mode set: one continuous period from on to off
// R15: yearly interval crosses new year; none after final off
// R16: date output follows the active cam condition exactly
// R17: irregular schedules use several timers merged by OR
// R18: comparisons evaluated once per scan tick
`include "cct_consts.svh"

module calendar_cam_timer (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scan_tick_i,
  input wire logic [6:0] rtc_year_i,
  input wire logic [3:0] rtc_month_i,
  input wire logic [4:0] rtc_day_i,
  input wire logic [2:0] rtc_wday_i,
  input wire logic [4:0] rtc_hour_i,
  input wire logic [5:0] rtc_min_i,
  output logic week_q_o,
  output logic date_q_o
);
  import cct_pkg::*;

  cct_state_t st_r;
  cct_state_t st_nxt;
  logic [`NUM_CAMS-1:0] on_hit;
  logic [`NUM_CAMS-1:0] off_hit;
  date_t nd;
  wtime_t nw;
  logic new_min;
  logic new_day;
  logic midnight;
  logic dlev;
  logic dpulse;
  logic [31:0] rd_word;
  logic map_hit;
  logic yr_bad;
  logic ro_hit;
  logic acc_err;
  logic wr_go;

  assign nd = st_r.now.d;
  assign nw = st_r.now.w;

  // inclusive year window
  function automatic logic in_yrs(input logic [6:0] y,
      input logic [6:0] lo, input logic [6:0] hi);
    return (y >= lo) && (y <= hi);
  endfunction : in_yrs

  // level of the date cam for a given day
  function automatic logic date_level(input date_t n,
      input date_t a, input date_t b, input logic [2:0] m);
    logic [8:0] nmd;
    logic [8:0] amd;
    logic [8:0] bmd;
    logic yok;
    logic lv;
    nmd = {n.mon, n.day};
    amd = {a.mon, a.day};
    bmd = {b.mon, b.day};
    yok = in_yrs(n.yr, a.yr, b.yr);
    lv = 1'b0;
    // R12: monthly checked first
    if (m[`MODE_MONTHLY]) begin
      // R10: day window each month
      if (a.day <= b.day) begin
        lv = (n.day >= a.day) && (n.day < b.day) && yok;
      end else begin
        // no on-edge in the last month of the final year
        lv = ((n.day >= a.day) && yok
          && !(n.yr == b.yr && n.mon == `LAST_MONTH))
          || ((n.day < b.day) && yok
          && !(n.yr == a.yr && n.mon == `FIRST_MONTH));
      end
    end else if (m[`MODE_YEARLY]) begin
      // R11: month-day window each year
      if (amd <= bmd) begin
        lv = (nmd >= amd) && (nmd < bmd) && yok;
      end else begin
        // R15: carry over new year, stop after final off
        lv = ((nmd >= amd) && yok && (n.yr != b.yr))
          || ((nmd < bmd) && yok && (n.yr != a.yr));
      end
    end else begin
      // R14: one uninterrupted span
      lv = (n >= a) && (n < b);
    end
    return lv;
  endfunction : date_level

  // R13: on-date occurrence for pulse mode
  function automatic logic date_hit(input date_t n,
      input date_t a, input date_t b, input logic [2:0] m);
    logic yok;
    logic h;
    yok = in_yrs(n.yr, a.yr, b.yr);
    if (m[`MODE_MONTHLY]) begin
      h = (n.day == a.day) && yok;
    end else if (m[`MODE_YEARLY]) begin
      h = (n.mon == a.mon) && (n.day == a.day) && yok;
    end else begin
      h = (n == a);
    end
    return h;
  endfunction : date_hit

  // R09: year low, then month, then day
  function automatic logic [31:0] date_word(input date_t d);
    return {11'h000, d.day, 4'h0, d.mon, 1'b0, d.yr};
  endfunction : date_word

  // one matcher per cam
  generate
    for (genvar c = 0; c < `NUM_CAMS; c++) begin : g_cam
      weekly_cam_match u_match (
        .days_i(st_r.days[c]),
        .time_i(st_r.times[c]),
        .now_i(nw),
        .on_hit_o(on_hit[c]),
        .off_hit_o(off_hit[c])
      );
    end
  endgenerate

  // event edges seen by the scan
  assign new_min = (nw != st_r.wk_seen);
  assign new_day = (nd != st_r.dt_seen);
  // R08: date pulses only at 00:00
  assign midnight = (nw.hr == `MIDNIGHT_HR)
    && (nw.mn == `MIDNIGHT_MIN);
  assign dlev = date_level(nd, st_r.don, st_r.doff, st_r.mode);
  assign dpulse = new_day && midnight
    && date_hit(nd, st_r.don, st_r.doff, st_r.mode);

  // register decode, shared by read and write
  always_comb begin
    rd_word = 32'h0000_0000;
    map_hit = 1'b0;
    yr_bad = 1'b0;
    ro_hit = 1'b0;
    case (paddr_i)
      `WK_CTRL_OFS: begin
        map_hit = 1'b1;
        rd_word[`WK_PULSE_BIT] = st_r.wk_pulse;
      end
      `DATE_CTRL_OFS: begin
        map_hit = 1'b1;
        rd_word[2:0] = st_r.mode;
      end
      `DATE_ON_OFS: begin
        map_hit = 1'b1;
        rd_word = date_word(st_r.don);
        yr_bad = pwdata_i[`YR_LSB +: 7] > `LAST_YEAR;
      end
      `DATE_OFF_OFS: begin
        map_hit = 1'b1;
        rd_word = date_word(st_r.doff);
        yr_bad = pwdata_i[`YR_LSB +: 7] > `LAST_YEAR;
      end
      `STATUS_OFS: begin
        map_hit = 1'b1;
        ro_hit = 1'b1;
        rd_word[`STAT_WK_BIT] = st_r.wk_q;
        rd_word[`STAT_DT_BIT] = st_r.dt_q;
      end
      default: begin
        map_hit = 1'b0;
      end
    endcase
    for (int i = 0; i < `NUM_CAMS; i++) begin
      if (paddr_i == `CAM_DAYS_OFS + 8'(i * 4)) begin
        map_hit = 1'b1;
        rd_word = {25'h0, st_r.days[i]};
      end
      if (paddr_i == `CAM_TIME_OFS + 8'(i * 4)) begin
        map_hit = 1'b1;
        rd_word = st_r.times[i];
      end
    end
  end

  // R07: years past 2099 refused with an error
  assign acc_err = !map_hit || (pwrite_i && (yr_bad || ro_hit));
  // write lands only on the completing access edge
  assign wr_go = psel_i && penable_i && pwrite_i
    && st_r.pready && !st_r.pslverr;

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // rtc pins pass three flops (s1, s2, s3) before reaching now
    st_nxt.s1 = {rtc_year_i, rtc_month_i, rtc_day_i,
      rtc_wday_i, rtc_hour_i, rtc_min_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // fields can tear mid-rollover; keep only settled samples
    if (st_r.s2 == st_r.s3) begin
      st_nxt.now = st_r.s3;
    end
    // setup cycle decodes, access cycle answers at once
    st_nxt.pready = psel_i && !penable_i;
    if (psel_i && !penable_i) begin
      st_nxt.prdata = pwrite_i ? 32'h0000_0000 : rd_word;
      st_nxt.pslverr = acc_err;
    end
    if (wr_go) begin
      case (paddr_i)
        `WK_CTRL_OFS: begin
          st_nxt.wk_pulse = pwdata_i[`WK_PULSE_BIT];
        end
        `DATE_CTRL_OFS: begin
          st_nxt.mode = pwdata_i[2:0];
        end
        // R09: fields unpacked year, month, day
        `DATE_ON_OFS: begin
          st_nxt.don = {pwdata_i[`YR_LSB +: 7],
            pwdata_i[`MON_LSB +: 4], pwdata_i[`DAY_LSB +: 5]};
        end
        `DATE_OFF_OFS: begin
          st_nxt.doff = {pwdata_i[`YR_LSB +: 7],
            pwdata_i[`MON_LSB +: 4], pwdata_i[`DAY_LSB +: 5]};
        end
        default: begin
          st_nxt.mode = st_r.mode;
        end
      endcase
      for (int i = 0; i < `NUM_CAMS; i++) begin
        if (paddr_i == `CAM_DAYS_OFS + 8'(i * 4)) begin
          st_nxt.days[i] = pwdata_i[6:0];
        end
        if (paddr_i == `CAM_TIME_OFS + 8'(i * 4)) begin
          st_nxt.times[i] = pwdata_i & `CAM_TIME_MASK;
        end
      end
    end
    // R18: outputs move only on a scan tick
    if (scan_tick_i) begin
      st_nxt.wk_seen = nw;
      st_nxt.dt_seen = nd;
      if (st_r.wk_pulse) begin
        // R03: high from the first scan in the on minute until the next scan
        st_nxt.wk_q = new_min && (|on_hit);
      end else if (new_min && (|on_hit)) begin
        // R05: any cam sets; R06: first on wins
        st_nxt.wk_q = 1'b1;
      end else if (new_min && (|off_hit)) begin
        // R06: first off clears, later offs idle
        st_nxt.wk_q = 1'b0;
      end
      if (st_r.mode[`MODE_PULSE]) begin
        // R13: one scan per occurrence
        st_nxt.dt_q = dpulse;
      end else begin
        // R16: follows the cam level; date rolls at midnight
        st_nxt.dt_q = dlev;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.times <= {`NUM_CAMS{`CAM_TIME_RST}};
      st_r.wk_seen <= `WK_SEEN_RST;
      st_r.dt_seen <= `DAY_SEEN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign week_q_o = st_r.wk_q;
  assign date_q_o = st_r.dt_q;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // R01: masked day blocks a hit
  a_day_mask_gate: assert property ( // R01
    (nw.wday != `NO_WDAY) && !st_r.days[0][nw.wday]
    |-> !on_hit[0])
    else $error("cam hit on a masked day");

  // R02: hits only at valid times
  a_time_range: assert property ( // R02
    |on_hit |-> (nw.hr <= `LAST_HOUR) && (nw.mn <= `LAST_MIN))
    else $error("cam hit outside day range");

  // R03: weekly pulse lasts one scan
  a_week_pulse: assert property ( // R03
    scan_tick_i && st_r.wk_pulse && st_r.wk_q && !new_min
    |=> !st_r.wk_q)
    else $error("weekly pulse longer than one scan");

  // R04: unset on time stays quiet
  a_unset_quiet: assert property ( // R04
    st_r.times[0][`ON_UNSET_BIT] |-> !on_hit[0])
    else $error("unset on time switched");

  // R05: third cam alone sets the output
  a_any_cam_sets: assert property ( // R05
    scan_tick_i && !st_r.wk_pulse && new_min && on_hit[2]
    |=> st_r.wk_q)
    else $error("cam three did not set output");

  // R06: earliest off clears
  a_early_off: assert property ( // R06
    scan_tick_i && !st_r.wk_pulse && new_min
    && (|off_hit) && !(|on_hit) |=> !st_r.wk_q)
    else $error("off time did not clear output");

  // R07: stored years stay in range
  a_year_limit: assert property ( // R07
    (st_r.don.yr <= `LAST_YEAR) && (st_r.doff.yr <= `LAST_YEAR))
    else $error("date year beyond range");

  // R08: no date pulse away from midnight
  a_midnight_only: assert property ( // R08
    scan_tick_i && st_r.mode[`MODE_PULSE] && !midnight
    |=> !st_r.dt_q)
    else $error("date pulse outside midnight");

  // R10: monthly on-day in a middle year turns on
  a_monthly_on: assert property ( // R10
    scan_tick_i && st_r.mode[`MODE_MONTHLY]
    && !st_r.mode[`MODE_PULSE] && (st_r.don.day < st_r.doff.day)
    && (nd.day == st_r.don.day) && (nd.yr > st_r.don.yr)
    && (nd.yr < st_r.doff.yr) |=> st_r.dt_q)
    else $error("monthly on-day missed");

  // R12: monthly off-day wins over yearly
  a_monthly_wins: assert property ( // R12
    scan_tick_i && (st_r.mode == 3'h3)
    && (st_r.don.day < st_r.doff.day)
    && (nd.day >= st_r.doff.day) |=> !st_r.dt_q)
    else $error("yearly window overrode monthly");

  // R15: nothing after the final year
  a_yearly_done: assert property ( // R15
    scan_tick_i && (st_r.mode == 3'h2)
    && (nd.yr > st_r.doff.yr) |=> !st_r.dt_q)
    else $error("yearly output after final year");

  // R13: date pulse clears next scan
  a_date_pulse: assert property ( // R13
    scan_tick_i && st_r.mode[`MODE_PULSE] && st_r.dt_q
    && !new_day |=> !st_r.dt_q)
    else $error("date pulse longer than one scan");

  // R14: single span is on inside it
  a_once_span: assert property ( // R14
    scan_tick_i && (st_r.mode == 3'h0) && (nd >= st_r.don)
    && (nd < st_r.doff) |=> st_r.dt_q)
    else $error("period output dropped");

  // R16: level mode mirrors the condition
  a_level_track: assert property ( // R16
    scan_tick_i && !st_r.mode[`MODE_PULSE]
    |=> st_r.dt_q == $past(dlev))
    else $error("date output not tracking level");

  // R18: outputs hold between scans
  a_scan_hold: assert property ( // R18
    !scan_tick_i |=> $stable(st_r.wk_q) && $stable(st_r.dt_q))
    else $error("output moved without scan tick");
endmodule : calendar_cam_timer

// ==== sim/rtc_model.sv ====
`timescale 1ns/1ps

module rtc_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire cct_pkg::rtc_t stamp_i,
  output logic [6:0] year_o,
  output logic [3:0] month_o,
  output logic [4:0] day_o,
  output logic [2:0] wday_o,
  output logic [4:0] hour_o,
  output logic [5:0] min_o
);
  import cct_pkg::*;
  rtc_t cur_r;

  // time jumps only when loaded, so each probe lands on an exact minute
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      cur_r <= stamp_i;
    end
  end

  // pins stay static between loads, as a stopped calendar would
  assign year_o = cur_r.d.yr;
  assign month_o = cur_r.d.mon;
  assign day_o = cur_r.d.day;
  assign wday_o = cur_r.w.wday;
  assign hour_o = cur_r.w.hr;
  assign min_o = cur_r.w.mn;
endmodule : rtc_model

// ==== sim/calendar_cam_timer_tb_top.sv ====
`timescale 1ns/1ps
`include "cct_consts.svh"

module calendar_cam_timer_tb_top;
  import cct_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic scan_tick_i = 1'b0;
  logic load = 1'b1;
  rtc_t stamp = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, week_q_o, date_q_o;
  logic [6:0] r_yr;
  logic [3:0] r_mon;
  logic [4:0] r_day, r_hr;
  logic [2:0] r_wd;
  logic [5:0] r_mn;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  rtc_model rtc (.clk_i(clk_sys_i), .load_i(load), .stamp_i(stamp),
    .year_o(r_yr), .month_o(r_mon), .day_o(r_day), .wday_o(r_wd),
    .hour_o(r_hr), .min_o(r_mn));

  calendar_cam_timer uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .scan_tick_i(scan_tick_i), .rtc_year_i(r_yr), .rtc_month_i(r_mon),
    .rtc_day_i(r_day), .rtc_wday_i(r_wd), .rtc_hour_i(r_hr),
    .rtc_min_i(r_mn), .week_q_o(week_q_o), .date_q_o(date_q_o));

  task check(input string nm, input logic [31:0] seen,
             input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // one apb transfer; waits on pready, never on a fixed count
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    check("pready seen", {31'h0, n < 20}, 32'h1);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  function automatic logic [31:0] ct(input logic [4:0] oh,
    input logic [5:0] om, input logic [4:0] fh, input logic [5:0] fm);
    return {3'h0, fh, 2'h0, fm, 3'h0, oh, 2'h0, om};
  endfunction : ct

  function automatic logic [31:0] dw(input logic [6:0] y,
    input logic [3:0] m, input logic [4:0] d);
    return {11'h0, d, 4'h0, m, 1'h0, y};
  endfunction : dw

  // synchroniser needs about five clocks, so allow eight
  task set_time(input logic [6:0] y, input logic [3:0] m,
    input logic [4:0] d, input logic [2:0] wd, input logic [4:0] h,
    input logic [5:0] mn);
    @(posedge clk_sys_i);
    load <= 1'b1;
    stamp <= {y, m, d, wd, h, mn};
    @(posedge clk_sys_i);
    load <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask : set_time

  task scan;
    @(posedge clk_sys_i);
    scan_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    scan_tick_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : scan

  task wk(input logic [2:0] wd, input logic [4:0] h,
    input logic [5:0] mn, input logic e);
    set_time(7'd0, 4'd1, 5'd1, wd, h, mn);
    scan();
    check("week out", {31'h0, week_q_o}, {31'h0, e});
  endtask : wk

  task dp(input logic [6:0] y, input logic [3:0] m, input logic [4:0] d,
    input logic [4:0] h, input logic [5:0] mn, input logic e);
    set_time(y, m, d, 3'd0, h, mn);
    scan();
    check("date out", {31'h0, date_q_o}, {31'h0, e});
  endtask : dp

  task dcase(input logic [2:0] md, input logic [31:0] on,
    input logic [31:0] off);
    wr(`DATE_CTRL_OFS, {29'h0, md});
    wr(`DATE_ON_OFS, on);
    wr(`DATE_OFF_OFS, off);
  endtask : dcase

  task t_regs;
    apb(1'b0, `CAM_TIME_OFS + 8'h04, 32'h0);
    check("cam time rst", rd, `CAM_TIME_RST);
    apb(1'b0, `CAM_DAYS_OFS, 32'h0);
    check("days rst", rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, `STATUS_OFS, 32'h3);
    check("status wr err", {31'h0, err}, 32'h1);
    wr(`DATE_ON_OFS, dw(7'd100, 4'd1, 5'd1));
    check("year 2100 err", {31'h0, err}, 32'h1);
    wr(`DATE_ON_OFS, dw(7'd99, 4'd12, 5'd31));
    check("year 2099 ok", {31'h0, err}, 32'h0);
    apb(1'b0, `DATE_ON_OFS, 32'h0);
    check("date fields", rd, dw(7'd99, 4'd12, 5'd31));
  endtask : t_regs

  task t_weekly;
    wr(`CAM_DAYS_OFS, 32'h02);
    wr(`CAM_TIME_OFS, ct(5'd6, 6'd30, 5'd8, 6'd0));
    set_time(7'd0, 4'd1, 5'd1, 3'd1, 5'd6, 6'd30);
    check("no scan", {31'h0, week_q_o}, 32'h0);
    wk(3'd0, 5'd6, 6'd30, 1'b0);
    wk(3'd1, 5'd6, 6'd30, 1'b1);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check("status", rd, 32'h1);
    wk(3'd1, 5'd8, 6'd0, 1'b0);
    wr(`CAM_TIME_OFS, ct(5'd23, 6'd59, 5'd0, 6'd0) | 32'h8000_0000);
    wk(3'd1, 5'd23, 6'd59, 1'b1);
    // overlapping cams: earliest on and earliest off win
    for (int i = 0; i < 3; i++) begin
      wr(`CAM_DAYS_OFS + 8'(4 * i), 32'h7f);
    end
    wr(`CAM_TIME_OFS, ct(5'd1, 6'd0, 5'd2, 6'd0));
    wr(`CAM_TIME_OFS + 8'h04, ct(5'd1, 6'd10, 5'd1, 6'd50));
    wr(`CAM_TIME_OFS + 8'h08, ct(5'd1, 6'd20, 5'd1, 6'd40));
    wk(3'd1, 5'd2, 6'd0, 1'b0);
    wk(3'd1, 5'd1, 6'd0, 1'b1);
    wk(3'd1, 5'd1, 6'd20, 1'b1);
    wk(3'd1, 5'd1, 6'd40, 1'b0);
    wk(3'd1, 5'd1, 6'd50, 1'b0);
    wr(`CAM_TIME_OFS, ct(5'd6, 6'd30, 5'd7, 6'd0) | 32'h0000_8000);
    wk(3'd1, 5'd6, 6'd30, 1'b0);
    wr(`CAM_TIME_OFS, ct(5'd5, 6'd0, 5'd6, 6'd0) | 32'h8000_0000);
    wk(3'd1, 5'd5, 6'd0, 1'b1);
    wk(3'd1, 5'd6, 6'd0, 1'b1);
    wr(`WK_CTRL_OFS, 32'h1);
    wr(`CAM_TIME_OFS, ct(5'd6, 6'd30, 5'd0, 6'd0) | 32'h8000_0000);
    wk(3'd1, 5'd6, 6'd30, 1'b1);
    scan();
    check("week pulse end", {31'h0, week_q_o}, 32'h0);
    wr(`WK_CTRL_OFS, 32'h0);
  endtask : t_weekly

  task t_date;
    dcase(3'd0, dw(7'd8, 4'd6, 5'd1), dw(7'd10, 4'd8, 5'd31));
    dp(7'd8, 4'd5, 5'd31, 5'd12, 6'd0, 1'b0);
    dp(7'd8, 4'd6, 5'd1, 5'd12, 6'd0, 1'b1);
    dp(7'd9, 4'd1, 5'd10, 5'd12, 6'd0, 1'b1);
    dp(7'd10, 4'd8, 5'd31, 5'd12, 6'd0, 1'b0);
    dcase(3'd2, dw(7'd8, 4'd6, 5'd1), dw(7'd10, 4'd8, 5'd31));
    dp(7'd9, 4'd7, 5'd4, 5'd12, 6'd0, 1'b1);
    dp(7'd9, 4'd9, 5'd1, 5'd12, 6'd0, 1'b0);
    dp(7'd11, 4'd7, 5'd1, 5'd12, 6'd0, 1'b0);
    dcase(3'd2, dw(7'd8, 4'd12, 5'd15), dw(7'd10, 4'd1, 5'd7));
    dp(7'd9, 4'd1, 5'd3, 5'd12, 6'd0, 1'b1);
    dp(7'd9, 4'd12, 5'd20, 5'd12, 6'd0, 1'b1);
    dp(7'd10, 4'd12, 5'd20, 5'd12, 6'd0, 1'b0);
    dcase(3'd1, dw(7'd8, 4'd1, 5'd1), dw(7'd10, 4'd1, 5'd5));
    // on-day itself in a middle year, so the monthly-on check fires
    dp(7'd9, 4'd3, 5'd1, 5'd12, 6'd0, 1'b1);
    dp(7'd9, 4'd3, 5'd10, 5'd12, 6'd0, 1'b0);
    dp(7'd11, 4'd3, 5'd2, 5'd12, 6'd0, 1'b0);
    dcase(3'd3, dw(7'd8, 4'd1, 5'd1), dw(7'd10, 4'd1, 5'd5));
    dp(7'd9, 4'd3, 5'd3, 5'd12, 6'd0, 1'b1);
    dp(7'd9, 4'd3, 5'd10, 5'd12, 6'd0, 1'b0);
    // single pulse: fires once at midnight, never in a later year
    dcase(3'd4, dw(7'd8, 4'd3, 5'd15), dw(7'd10, 4'd1, 5'd1));
    dp(7'd8, 4'd3, 5'd14, 5'd23, 6'd59, 1'b0);
    dp(7'd8, 4'd3, 5'd15, 5'd0, 6'd0, 1'b1);
    scan();
    check("date pulse end", {31'h0, date_q_o}, 32'h0);
    dp(7'd9, 4'd3, 5'd14, 5'd23, 6'd59, 1'b0);
    dp(7'd9, 4'd3, 5'd15, 5'd0, 6'd0, 1'b0);
    dcase(3'd6, dw(7'd8, 4'd3, 5'd15), dw(7'd12, 4'd1, 5'd1));
    dp(7'd10, 4'd3, 5'd14, 5'd23, 6'd59, 1'b0);
    dp(7'd10, 4'd3, 5'd15, 5'd0, 6'd7, 1'b0);
    dp(7'd11, 4'd3, 5'd14, 5'd23, 6'd59, 1'b0);
    dp(7'd11, 4'd3, 5'd15, 5'd0, 6'd0, 1'b1);
    // monthly pulse: fires on the on-day of any month, inside the years
    dcase(3'd5, dw(7'd8, 4'd1, 5'd10), dw(7'd10, 4'd1, 5'd1));
    dp(7'd9, 4'd4, 5'd10, 5'd0, 6'd0, 1'b1);
    dp(7'd11, 4'd4, 5'd10, 5'd0, 6'd0, 1'b0);
    // one window per timer; irregular plans OR several timers outside
  endtask : t_date

  // hang guard, well above the roughly 650 cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    load <= 1'b0;
    t_regs();
    t_weekly();
    t_date();
    summarize();
  end
endmodule : calendar_cam_timer_tb_top
